// *** core/flash_spm_pkg.sv ***
package flash_spm_pkg;
  // ***********************************************
  // control register bit positions
  // ***********************************************
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned ERASE_BIT = 1;
  localparam int unsigned WRITE_BIT = 2;
  localparam int unsigned LOCK_BIT = 3;
  localparam int unsigned REEN_BIT = 4;
  localparam int unsigned BUSY_BIT = 6;
  localparam int unsigned IE_BIT = 7;
  // ***********************************************
  // command codes in bits 5..0 (bit 6 is the busy flag)
  // ***********************************************
  localparam logic [5:0] CMD_ERASE = 6'h03;
  localparam logic [5:0] CMD_FILL = 6'h01;
  localparam logic [5:0] CMD_WRITE = 6'h05;
  localparam logic [5:0] CMD_LOCK = 6'h09;
  localparam logic [5:0] CMD_REEN = 6'h11;
  // ***********************************************
  // timing and reset values
  // ***********************************************
  localparam int unsigned ARM_WINDOW = 4;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned PROG_TIME_MIN_US = 3700;
  localparam int unsigned PROG_TIME_MAX_US = 4500;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MIN_US * CLK_MHZ;
  localparam logic [15:0] APP_RESET_VECTOR = 16'h0000;
  localparam logic [5:0] LOCK_RESET = 6'h3F;
  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_WRITE, OP_LOCK} op_t;
endpackage

// *** core/flash_self_program_sequencer.sv ***
// What this block does
// - reset vector is application address if fuse is 1, boot start if 0.
// - pointer low bits pick word in page, high bits pick page.
// - operation address latched at start; later pointer changes ignored.
// - lock-bit setting ignores the pointer entirely.
// - program-memory loads address bytes, pointer bit 0 picks the byte.
// - erase on code X0000011 then store within four cycles, page field only.
// - erase of halting region halts the CPU; other erase keeps fetching.
// - fill on code 00000001 then store; data goes to word-in-page slot.
// - buffer cleared after page write, on read re-enable, and on reset.
// - buffer loads accepted in any order within the page.
// - EEPROM write during buffer loading discards all loaded data.
// - page write on code X0000101 then store; pointer holds page only.
// - write to halting region halts the CPU; other write keeps fetching.
// - interrupt enabled gives constant request while enable bit is clear.
// - during erase or write, block reads of rw region, hold busy flag.
// - busy stays set after completion until re-enable code X0010001 is stored.
// - lock code X0001001 programs lock bits whose data bits 5..0 are zero.
// - lock programming keeps whole flash readable.
// - EEPROM write in progress refuses all self-programming commands.
// - enable and lock-set self-clear without a store in four cycles.
// - erase, write and lock timed 3.7 ms, the minimum programming time.
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_sequencer #(
  parameter int unsigned PAGE_WORDS_LOG2 = 6,
  parameter int unsigned PROG_CYCLES = flash_spm_pkg::PROG_CYCLES,
  parameter logic [15:0] BOOT_START = 16'h3800,
  parameter logic [15:0] RW_REGION_LIMIT = 16'h3800
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  input wire logic store_exec,
  input wire logic [15:0] z_pointer,
  input wire logic [15:0] store_data,
  input wire logic eeprom_write_active,
  input wire logic boot_reset_select_fuse,
  input wire logic [15:0] lpm_byte_addr_in,
  output logic [15:0] reset_vector,
  output logic [14:0] lpm_word_addr,
  output logic lpm_high_byte,
  output logic cpu_halt,
  output logic rw_region_read_block,
  output logic spm_irq,
  output logic [5:0] lock_bits,
  output logic buf_wr,
  output logic [PAGE_WORDS_LOG2-1:0] buf_wr_word,
  output logic [15:0] buf_wr_data,
  output logic buf_clear,
  output logic flash_op_start,
  output logic [1:0] flash_op,
  output logic [15:0] flash_page_addr
);
  localparam int unsigned PW = PAGE_WORDS_LOG2;

  // ***********************************************
  // decode helpers
  // ***********************************************
  // word addresses below the limit belong to the read-while-write region
  function automatic logic in_rw_region(input logic [15:0] word_addr);
    in_rw_region = word_addr < RW_REGION_LIMIT;
  endfunction

  // erase, write and lock run timed; every other code ends at its store
  function automatic logic is_timed(input logic [5:0] code);
    is_timed = code == flash_spm_pkg::CMD_ERASE ||
               code == flash_spm_pkg::CMD_WRITE ||
               code == flash_spm_pkg::CMD_LOCK;
  endfunction

  logic program_op_enable_q;
  logic lock_bits_set_q;
  logic page_erase_select_q;
  logic page_write_select_q;
  logic rw_region_read_reenable_q;
  logic irq_enable_q;
  logic rw_region_busy_flag_q;
  logic [2:0] arm_cnt_q;
  logic [31:0] timer_q;
  flash_spm_pkg::op_t op_q;
  logic [15:0] op_addr_q;
  logic halt_q;
  logic [5:0] lock_q;
  logic armed;
  logic store_taken;
  logic [5:0] cmd;
  logic [15:0] page_word_addr;

  assign armed = program_op_enable_q && (op_q == flash_spm_pkg::OP_NONE);
  // a store counts only when armed and no EEPROM write is running
  assign store_taken = armed && store_exec && !eeprom_write_active;
  assign cmd = {1'b0, rw_region_read_reenable_q, lock_bits_set_q,
                page_write_select_q, page_erase_select_q,
                program_op_enable_q};
  // page field kept, word field zeroed
  assign page_word_addr = {z_pointer[15:PW], {PW{1'b0}}};

  // ***********************************************
  // control register and arming window
  // ***********************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      program_op_enable_q <= 1'b0;
      lock_bits_set_q <= 1'b0;
      page_erase_select_q <= 1'b0;
      page_write_select_q <= 1'b0;
      rw_region_read_reenable_q <= 1'b0;
      irq_enable_q <= 1'b0;
      arm_cnt_q <= 3'h0;
    end else if (op_q != flash_spm_pkg::OP_NONE) begin
      // enable stays up until the timed operation finishes
      if (timer_q == 32'h0000_0001) begin
        program_op_enable_q <= 1'b0;
        lock_bits_set_q <= 1'b0;
        page_erase_select_q <= 1'b0;
        page_write_select_q <= 1'b0;
      end
      // only the interrupt enable may change while an operation runs
      if (ctrl_wr) begin
        irq_enable_q <= ctrl_wdata[flash_spm_pkg::IE_BIT];
      end
    end else if (ctrl_wr && !eeprom_write_active) begin
      irq_enable_q <= ctrl_wdata[flash_spm_pkg::IE_BIT];
      program_op_enable_q <= ctrl_wdata[flash_spm_pkg::EN_BIT];
      page_erase_select_q <= ctrl_wdata[flash_spm_pkg::ERASE_BIT];
      page_write_select_q <= ctrl_wdata[flash_spm_pkg::WRITE_BIT];
      lock_bits_set_q <= ctrl_wdata[flash_spm_pkg::LOCK_BIT];
      rw_region_read_reenable_q <= ctrl_wdata[flash_spm_pkg::REEN_BIT];
      // the window counts the cycles in which a store is still accepted
      arm_cnt_q <= 3'(flash_spm_pkg::ARM_WINDOW);
    end else if (ctrl_wr) begin
      irq_enable_q <= ctrl_wdata[flash_spm_pkg::IE_BIT];
    end else if (armed && store_exec) begin
      // untimed codes end here; so does a store refused for a busy
      // EEPROM, otherwise the enable would stay up with no window left
      if (eeprom_write_active || !is_timed(cmd)) begin
        program_op_enable_q <= 1'b0;
        lock_bits_set_q <= 1'b0;
        page_erase_select_q <= 1'b0;
        page_write_select_q <= 1'b0;
        rw_region_read_reenable_q <= 1'b0;
      end
      arm_cnt_q <= 3'h0;
    end else if (armed) begin
      if (arm_cnt_q == 3'h1) begin
        program_op_enable_q <= 1'b0;
        lock_bits_set_q <= 1'b0;
        page_erase_select_q <= 1'b0;
        page_write_select_q <= 1'b0;
        rw_region_read_reenable_q <= 1'b0;
      end
      if (arm_cnt_q != 3'h0) begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
      end
    end
  end

  // ***********************************************
  // operation launch and timing
  // ***********************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      op_q <= flash_spm_pkg::OP_NONE;
      op_addr_q <= 16'h0000;
      timer_q <= 32'h0000_0000;
      halt_q <= 1'b0;
      flash_op_start <= 1'b0;
    end else begin
      flash_op_start <= 1'b0;
      if (op_q != flash_spm_pkg::OP_NONE) begin
        timer_q <= timer_q - 32'h0000_0001;
        if (timer_q == 32'h0000_0001) begin
          op_q <= flash_spm_pkg::OP_NONE;
          halt_q <= 1'b0;
        end
      end else if (store_taken) begin
        // the op stands PROG_CYCLES cycles and ends on the edge where
        // the timer reads one
        timer_q <= 32'(PROG_CYCLES);
        if (cmd == flash_spm_pkg::CMD_ERASE) begin
          op_q <= flash_spm_pkg::OP_ERASE;
          op_addr_q <= page_word_addr;
          halt_q <= !in_rw_region(page_word_addr);
          flash_op_start <= 1'b1;
        end else if (cmd == flash_spm_pkg::CMD_WRITE) begin
          op_q <= flash_spm_pkg::OP_WRITE;
          op_addr_q <= page_word_addr;
          halt_q <= !in_rw_region(page_word_addr);
          flash_op_start <= 1'b1;
        end else if (cmd == flash_spm_pkg::CMD_LOCK) begin
          op_q <= flash_spm_pkg::OP_LOCK;
          op_addr_q <= 16'h0000;
          halt_q <= 1'b0;
          flash_op_start <= 1'b1;
        end
      end
    end
  end

  // ***********************************************
  // lock bits, programmed bits read as zero
  // ***********************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_q <= flash_spm_pkg::LOCK_RESET;
    end else if (armed && store_exec && !eeprom_write_active &&
                 cmd == flash_spm_pkg::CMD_LOCK) begin
      // lock bits only ever move toward programmed
      lock_q <= lock_q & store_data[5:0];
    end
  end

  // ***********************************************
  // busy flag of the read-while-write region
  // ***********************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rw_region_busy_flag_q <= 1'b0;
    end else if (armed && store_exec && !eeprom_write_active &&
                 (cmd == flash_spm_pkg::CMD_ERASE ||
                  cmd == flash_spm_pkg::CMD_WRITE)) begin
      rw_region_busy_flag_q <= 1'b1;
    end else if (armed && store_exec && !eeprom_write_active &&
                 cmd == flash_spm_pkg::CMD_REEN) begin
      rw_region_busy_flag_q <= 1'b0;
    end
  end

  // ***********************************************
  // temporary page buffer strobes
  // ***********************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      buf_wr <= 1'b0;
      buf_wr_word <= '0;
      buf_wr_data <= 16'h0000;
      buf_clear <= 1'b1;
    end else begin
      buf_wr <= 1'b0;
      buf_clear <= 1'b0;
      // an EEPROM write throws away any partly loaded page
      if (eeprom_write_active) begin
        buf_clear <= 1'b1;
      end else if (op_q == flash_spm_pkg::OP_WRITE &&
                   timer_q == 32'h0000_0001) begin
        buf_clear <= 1'b1;
      end else if (armed && store_exec) begin
        if (cmd == flash_spm_pkg::CMD_REEN) begin
          buf_clear <= 1'b1;
        end else if (cmd == flash_spm_pkg::CMD_FILL) begin
          buf_wr <= 1'b1;
          // any word slot is accepted, no order tracked
          buf_wr_word <= z_pointer[PW-1:0];
          buf_wr_data <= store_data;
        end
      end
    end
  end

  // ***********************************************
  // registered outputs
  // ***********************************************
  // outputs trail the internal state by one register, so flash_op,
  // cpu_halt and the busy mirror follow the start pulse a cycle later
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_rdata <= 8'h00;
      reset_vector <= flash_spm_pkg::APP_RESET_VECTOR;
      lpm_word_addr <= 15'h0000;
      lpm_high_byte <= 1'b0;
      cpu_halt <= 1'b0;
      rw_region_read_block <= 1'b0;
      spm_irq <= 1'b0;
      lock_bits <= flash_spm_pkg::LOCK_RESET;
      flash_op <= 2'h0;
      flash_page_addr <= 16'h0000;
    end else begin
      ctrl_rdata <= {irq_enable_q, rw_region_busy_flag_q, 1'b0,
                     rw_region_read_reenable_q, lock_bits_set_q,
                     page_write_select_q, page_erase_select_q,
                     program_op_enable_q};
      reset_vector <= boot_reset_select_fuse ?
                      flash_spm_pkg::APP_RESET_VECTOR : BOOT_START;
      lpm_word_addr <= lpm_byte_addr_in[15:1];
      lpm_high_byte <= lpm_byte_addr_in[0];
      cpu_halt <= halt_q;
      rw_region_read_block <= rw_region_busy_flag_q;
      spm_irq <= irq_enable_q && !program_op_enable_q;
      lock_bits <= lock_q;
      flash_op <= op_q;
      flash_page_addr <= op_addr_q;
    end
  end
endmodule
`default_nettype wire

// *** tb/flash_spm_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module flash_spm_checker #(
  parameter int unsigned PAGE_WORDS_LOG2 = 6,
  parameter logic [15:0] BOOT_START = 16'h3800
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic eeprom_write_active,
  input wire logic boot_reset_select_fuse,
  input wire logic [15:0] lpm_byte_addr_in,
  input wire logic [15:0] reset_vector,
  input wire logic [14:0] lpm_word_addr,
  input wire logic lpm_high_byte,
  input wire logic cpu_halt,
  input wire logic rw_region_read_block,
  input wire logic buf_wr,
  input wire logic buf_clear,
  input wire logic flash_op_start,
  input wire logic [1:0] flash_op,
  input wire logic [15:0] flash_page_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_vector_sel: assert property ($stable(boot_reset_select_fuse) |=>
    reset_vector == (boot_reset_select_fuse ? 16'h0000 : BOOT_START))
    else $error("reset vector does not follow fuse");
  chk_lpm_split: assert property ($stable(lpm_byte_addr_in) |=>
    {lpm_word_addr, lpm_high_byte} == $past(lpm_byte_addr_in))
    else $error("load address split wrong");
  chk_page_field: assert property (flash_op_start |=>
    flash_page_addr[PAGE_WORDS_LOG2-1:0] == '0)
    else $error("page address keeps word bits");
  chk_start_op: assert property (flash_op_start |=> flash_op != 2'h0)
    else $error("no operation after start");
  chk_op_len: assert property ($rose(flash_op != 2'h0) |->
    (flash_op != 2'h0)[*8]) else $error("operation too short");
  chk_halt_op: assert property (cpu_halt |-> flash_op inside {2'h1, 2'h2})
    else $error("halt outside erase or write");
  chk_busy_op: assert property (
    flash_op inside {2'h1, 2'h2} |-> rw_region_read_block)
    else $error("region readable during erase or write");
  chk_lock_open: assert property (flash_op == 2'h3 |-> !cpu_halt)
    else $error("cpu halted during lock programming");
  chk_ee_clear: assert property (eeprom_write_active |=> buf_clear)
    else $error("buffer kept during eeprom write");
  chk_buf_pulse: assert property (buf_wr |=> !buf_wr)
    else $error("buffer load longer than one cycle");
endmodule
`default_nettype wire

// *** tb/cpu_loader_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpu_loader_model (
  input wire logic core_clk,
  output logic ctrl_wr,
  output logic [7:0] ctrl_wdata,
  output logic store_exec,
  output logic [15:0] z_pointer,
  output logic [15:0] store_data
);
  initial begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 8'h00;
    store_exec = 1'b0;
    z_pointer = 16'h0000;
    store_data = 16'h0000;
  end
  // control write, then the store after gap idle cycles
  task automatic spm(input logic [7:0] code, input logic [15:0] z,
    input logic [15:0] d, input int gap);
    @(negedge core_clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= code;
    z_pointer <= z;
    store_data <= d;
    @(negedge core_clk);
    ctrl_wr <= 1'b0;
    ctrl_wdata <= ~code;
    repeat (gap) @(negedge core_clk);
    store_exec <= 1'b1;
    @(negedge core_clk);
    store_exec <= 1'b0;
    // pointer reused at once, the latched page must not move
    z_pointer <= ~z;
    store_data <= ~d;
  endtask
endmodule
`default_nettype wire

// *** tb/flash_self_program_sequencer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_sequencer_tb;
  // ********
  // bench
  // ********
  logic core_clk, reset, eeprom_write_active, boot_reset_select_fuse;
  logic ctrl_wr, store_exec, lpm_high_byte, cpu_halt, rw_region_read_block;
  logic spm_irq, buf_wr, buf_clear, flash_op_start;
  logic [7:0] ctrl_wdata, ctrl_rdata;
  logic [15:0] z_pointer, store_data, lpm_byte_addr_in, reset_vector;
  logic [15:0] buf_wr_data, flash_page_addr;
  logic [14:0] lpm_word_addr;
  logic [5:0] lock_bits, buf_wr_word;
  logic [1:0] flash_op;
  int n_fail = 0;
  int n_compared = 0;
  flash_self_program_sequencer #(.PROG_CYCLES(20)) dut (
    .core_clk(core_clk), .reset(reset), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .store_exec(store_exec), .z_pointer(z_pointer), .store_data(store_data),
    .eeprom_write_active(eeprom_write_active),
    .boot_reset_select_fuse(boot_reset_select_fuse),
    .lpm_byte_addr_in(lpm_byte_addr_in), .reset_vector(reset_vector),
    .lpm_word_addr(lpm_word_addr), .lpm_high_byte(lpm_high_byte),
    .cpu_halt(cpu_halt), .rw_region_read_block(rw_region_read_block),
    .spm_irq(spm_irq), .lock_bits(lock_bits), .buf_wr(buf_wr),
    .buf_wr_word(buf_wr_word), .buf_wr_data(buf_wr_data),
    .buf_clear(buf_clear), .flash_op_start(flash_op_start),
    .flash_op(flash_op), .flash_page_addr(flash_page_addr));
  cpu_loader_model cpu (.core_clk(core_clk), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .store_exec(store_exec),
    .z_pointer(z_pointer), .store_data(store_data));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // polling is bounded so a stuck enable cannot hang the run
  task automatic wait_idle(output logic cleared);
    cleared = 1'b0;
    for (int i = 0; i < 60 && ctrl_rdata[0] !== 1'b0; i++) begin
      step(1);
      cleared = cleared | buf_clear;
    end
    cmp(16'(ctrl_rdata[0]), 16'h0000);
  endtask
  task automatic reenable();
    cpu.spm(8'h11, 16'h0000, 16'h0000, 0);
    cmp(16'(buf_clear), 16'h0001);
    step(2);
    cmp(16'(rw_region_read_block), 16'h0000);
    cmp(16'(ctrl_rdata[6]), 16'h0000);
  endtask
  task automatic t_erase(input logic [15:0] z, input logic halt);
    logic c;
    cpu.spm(8'h83, z, 16'hFFFF, 0);
    cmp(16'(flash_op_start), 16'h0001);
    step(1);
    cmp(flash_page_addr, z & 16'hFFC0);
    step(1);
    cmp(16'(flash_op), 16'h0001);
    cmp(16'(cpu_halt), 16'(halt));
    cmp(16'(spm_irq), 16'h0000);
    wait_idle(c);
    step(1);
    cmp(flash_page_addr, z & 16'hFFC0);
    cmp(16'(spm_irq), 16'h0001);
    cmp(16'(ctrl_rdata[6]), 16'h0001);
    reenable();
  endtask
  task automatic t_fill_write();
    logic c;
    logic [15:0] w [2] = '{16'h0025, 16'h0002};
    for (int i = 0; i < 2; i++) begin
      cpu.spm(8'h01, w[i], w[i] ^ 16'hA5C3, 0);
      cmp(16'(buf_wr), 16'h0001);
      cmp(16'(buf_wr_word), w[i]);
      cmp(buf_wr_data, w[i] ^ 16'hA5C3);
    end
    cpu.spm(8'h05, 16'h3840, 16'h0000, 0);
    step(2);
    cmp(16'(flash_op), 16'h0002);
    cmp(flash_page_addr, 16'h3840);
    cmp(16'(cpu_halt), 16'h0001);
    wait_idle(c);
    cmp(16'(c), 16'h0001);
    reenable();
  endtask
  task automatic t_lock_refuse();
    logic c;
    cpu.spm(8'h09, 16'hBEEF, 16'h00F5, 0);
    step(2);
    cmp(16'(flash_op), 16'h0003);
    cmp(flash_page_addr, 16'h0000);
    cmp(16'(rw_region_read_block), 16'h0000);
    wait_idle(c);
    cmp(16'(lock_bits), 16'h0035);
    cpu.spm(8'h01, 16'h0007, 16'h1234, 3);
    cmp(16'(buf_wr), 16'h0001);
    cpu.spm(8'h03, 16'h1000, 16'h0000, 6);
    cmp(16'(flash_op_start), 16'h0000);
    step(1);
    cmp(16'(ctrl_rdata[0]), 16'h0000);
    eeprom_write_active = 1'b1;
    cpu.spm(8'h03, 16'h1000, 16'h0000, 0);
    cmp(16'(flash_op_start), 16'h0000);
    step(1);
    cmp(16'(buf_clear), 16'h0001);
    eeprom_write_active = 1'b0;
  endtask
  initial begin
    #25000;
    n_fail++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    eeprom_write_active = 1'b0;
    boot_reset_select_fuse = 1'b1;
    lpm_byte_addr_in = 16'h0000;
    step(16);
    reset = 1'b0;
    step(2);
    cmp(reset_vector, 16'h0000);
    t_erase(16'h1245, 1'b0);
    t_erase(16'h3851, 1'b1);
    t_fill_write();
    t_lock_refuse();
    lpm_byte_addr_in = 16'h1235;
    step(2);
    cmp({lpm_word_addr, lpm_high_byte}, 16'h1235);
    reset = 1'b1;
    boot_reset_select_fuse = 1'b0;
    step(16);
    reset = 1'b0;
    step(2);
    cmp(reset_vector, 16'h3800);
    end_sim();
  end
endmodule
bind flash_self_program_sequencer flash_spm_checker #(
  .PAGE_WORDS_LOG2(PAGE_WORDS_LOG2), .BOOT_START(BOOT_START)) chk (
  .core_clk(core_clk), .reset(reset),
  .eeprom_write_active(eeprom_write_active),
  .boot_reset_select_fuse(boot_reset_select_fuse),
  .lpm_byte_addr_in(lpm_byte_addr_in), .reset_vector(reset_vector),
  .lpm_word_addr(lpm_word_addr), .lpm_high_byte(lpm_high_byte),
  .cpu_halt(cpu_halt), .rw_region_read_block(rw_region_read_block),
  .buf_wr(buf_wr), .buf_clear(buf_clear), .flash_op_start(flash_op_start),
  .flash_op(flash_op), .flash_page_addr(flash_page_addr));
`default_nettype wire
